// File: hw/eiv_pkg.sv
`default_nettype none
package eiv_pkg;
  // ----------------------------------------------------------------
  // Register offsets (data-space addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] IO_OFFSET      = 8'h20;
  localparam logic [7:0] ADDR_CHG_FLAGS = 8'h3B;
  localparam logic [7:0] ADDR_EXT_FLAGS = 8'h3C;
  localparam logic [7:0] ADDR_EXT_MASK  = 8'h3D;
  localparam logic [7:0] ADDR_CORE_CTL  = 8'h55;
  localparam logic [7:0] ADDR_CHG_EN    = 8'h68;
  localparam logic [7:0] ADDR_SENSE     = 8'h69;
  localparam logic [7:0] ADDR_CHG_MASK0 = 8'h6B;
  localparam logic [7:0] ADDR_CHG_MASK1 = 8'h6C;
  localparam logic [7:0] ADDR_CHG_MASK2 = 8'h6D;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          VSEL_BIT   = 1;
  localparam int          VCE_BIT    = 0;
  localparam int          SENSE1_LSB = 2;
  localparam int          SENSE0_LSB = 0;
  localparam logic [7:0]  RESET_VAL  = 8'h00;
  localparam logic [7:0]  BANK1_BITS = 8'h7F;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [2:0]  VCE_CYCLES = 3'h4;
  // ----------------------------------------------------------------
  // Sense modes
  // ----------------------------------------------------------------
  localparam logic [1:0]  SENSE_LOW  = 2'h0;
  localparam logic [1:0]  SENSE_ANY  = 2'h1;
  localparam logic [1:0]  SENSE_FALL = 2'h2;
  localparam logic [1:0]  SENSE_RISE = 2'h3;
endpackage
`default_nettype wire

// File: hw/eiv_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
// Per-pin detector connection: config in, event and level out
interface eiv_pin_if;
  logic [1:0] sense;
  logic       pin;
  logic       event_hit;
  logic       level_low;
  modport ctl (output sense, output pin, input event_hit, input level_low);
  modport det (input sense, input pin, output event_hit, output level_low);
endinterface
`default_nettype wire

// File: hw/eiv_pin_detect.sv
`timescale 1ns/1ps
`default_nettype none
module eiv_pin_detect (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  eiv_pin_if.det    p
);
  logic samp;
  logic prev;

  // ----------------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------------
  // Pin taken as synchronous; one sample kept for edge compare
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      samp <= 1'b1;
      prev <= 1'b1;
    end else begin
      samp <= p.pin;                       // [R3]
      prev <= samp;                        // [R24]
    end
  end

  // Level path bypasses the edge compare so a low wakes without edges
  assign p.level_low = ~p.pin;             // [R6]

  // One event per clock at most
  always_comb begin
    unique case (p.sense)
      eiv_pkg::SENSE_LOW:  p.event_hit = 1'b0;
      eiv_pkg::SENSE_ANY:  p.event_hit = samp ^ prev;      // [R1]
      eiv_pkg::SENSE_FALL: p.event_hit = prev & ~samp;     // [R1]
      eiv_pkg::SENSE_RISE: p.event_hit = ~prev & samp;     // [R1]
    endcase
  end
endmodule
`default_nettype wire

// File: hw/eiv_ctl.sv
// Behaviour
// R1 - Sense field picks low/any/fall/rise
// R2 - Sense register: pin1 bits 3:2, pin0 1:0
// R3 - Pin sampled; pulses over one clock caught
// R4 - Driver holds low level through instruction
// R5 - Level mode requests while pin low
// R6 - Edges need clock; low level asynchronous
// R7 - Three banks raise request on toggle
// R8 - Pin-change detection works without clock
// R9 - Interrupts fire even when pin is output
// R10 - Dedicated request needs mask and global
// R11 - Edge sets flag; vector or W1C clears
// R12 - Level mode holds pending flag clear
// R13 - Driver holds wake level through start-up
// R14 - Vector select chooses application or boot
// R15 - Software sets change-enable then writes select
// R16 - Change-enable self-clears after four cycles
// R17 - Change sequence blocks interrupts, global untouched
// R18 - Boot lock bits block cross-region interrupts
// R19 - I/O instructions use offset minus 0x20
// R20 - Bank enables plus global gate requests
// R21 - Per-input mask enables change detection
// R22 - Bank change sets flag; clears likewise
// R23 - Pin zero flag behaves like pin one
// R24 - Edge compares current and previous sample
`timescale 1ns/1ps
`default_nettype none
module eiv_ctl #(
  parameter int BANK_W = 8
) (
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire logic [7:0]        addr_in,
  input  wire logic              io_space_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              global_ie_in,
  input  wire logic              instr_done_in,
  input  wire logic              exec_boot_in,
  input  wire logic              app_lock_bit_in,
  input  wire logic              boot_lock_bit_in,
  input  wire logic [4:0]        vector_ack_in,
  input  wire logic [1:0]        ext_pin_in,
  input  wire logic [3*BANK_W-1:0] change_input_in,
  output logic [7:0]             rdata_out,
  output logic [4:0]             irq_req_out,
  output logic                   vector_table_select_out,
  output logic                   wake_out
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]        sense_ctl;
  logic [1:0]        ext_mask;
  logic [1:0]        ext_pend;
  logic [2:0]        bank_en;
  logic [2:0]        bank_pend;
  logic [BANK_W-1:0] bank_mask [3];
  logic              vsel;
  logic              vce;
  logic [2:0]        vce_cnt;
  logic              block_seq;
  logic              block_hold;
  logic [3*BANK_W-1:0] chg_prev;
  logic [1:0]        hit;
  logic [1:0]        lvl;
  logic [2:0]        bank_hit;
  logic [7:0]        eff_addr;
  logic              wr_ctl;

  // Dedicated I/O instructions use the offset less 0x20
  assign eff_addr = io_space_in ? 8'(addr_in + eiv_pkg::IO_OFFSET)
                                : addr_in;  // [R19]
  assign wr_ctl = wr_in && eff_addr == eiv_pkg::ADDR_CORE_CTL;

  // ----------------------------------------------------------------
  // Dedicated pin detectors
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_pin
      eiv_pin_if pif ();
      assign pif.sense = sense_ctl[2*g +: 2];  // [R2]
      assign pif.pin   = ext_pin_in[g];        // [R9]
      assign hit[g]    = pif.event_hit;
      assign lvl[g]    = pif.level_low;
      eiv_pin_detect u_det (
        .clk_in    (clk_in),
        .reset_n_in(reset_n_in),
        .p         (pif)
      );
    end
  endgenerate

  function automatic logic is_level(input logic [1:0] s);
    return s == eiv_pkg::SENSE_LOW;
  endfunction

  // Pin-change compare per masked input; mask gates detection itself
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) chg_prev <= '0;
    else             chg_prev <= change_input_in;
  end
  always_comb begin
    for (int b = 0; b < 3; b++) begin
      bank_hit[b] = |((change_input_in[b*BANK_W +: BANK_W] ^
                       chg_prev[b*BANK_W +: BANK_W]) &
                      bank_mask[b]);           // [R7] [R21]
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sense_ctl <= eiv_pkg::RESET_VAL;
      ext_mask  <= '0;
      bank_en   <= '0;
      for (int b = 0; b < 3; b++) bank_mask[b] <= '0;
    end else if (wr_in) begin
      unique case (eff_addr)
        eiv_pkg::ADDR_SENSE:     sense_ctl <= {4'h0, wdata_in[3:0]}; // [R2]
        eiv_pkg::ADDR_EXT_MASK:  ext_mask  <= wdata_in[1:0];  // [R10]
        eiv_pkg::ADDR_CHG_EN:    bank_en   <= wdata_in[2:0];  // [R20]
        eiv_pkg::ADDR_CHG_MASK0: bank_mask[0] <= wdata_in[BANK_W-1:0];
        eiv_pkg::ADDR_CHG_MASK1:
          bank_mask[1] <= wdata_in[BANK_W-1:0] &
                          eiv_pkg::BANK1_BITS[BANK_W-1:0];
        eiv_pkg::ADDR_CHG_MASK2: bank_mask[2] <= wdata_in[BANK_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pending flags: set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_pend <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (is_level(sense_ctl[2*i +: 2]))
          ext_pend[i] <= 1'b0;                        // [R12] [R23]
        else if (hit[i])
          ext_pend[i] <= 1'b1;                        // [R11] [R3]
        else if (vector_ack_in[i] ||
                 (wr_in && eff_addr == eiv_pkg::ADDR_EXT_FLAGS &&
                  wdata_in[i]))
          ext_pend[i] <= 1'b0;                        // [R11]
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bank_pend <= '0;
    end else begin
      for (int b = 0; b < 3; b++) begin
        if (bank_hit[b])
          bank_pend[b] <= 1'b1;                       // [R22]
        else if (vector_ack_in[2+b] ||
                 (wr_in && eff_addr == eiv_pkg::ADDR_CHG_FLAGS &&
                  wdata_in[b]))
          bank_pend[b] <= 1'b0;                       // [R22]
      end
    end
  end

  // ----------------------------------------------------------------
  // Vector table select and timed change window
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      vsel    <= 1'b0;
      vce     <= 1'b0;
      vce_cnt <= '0;
    end else if (wr_ctl && wdata_in[eiv_pkg::VCE_BIT]) begin
      vce     <= 1'b1;                                // [R15]
      vce_cnt <= eiv_pkg::VCE_CYCLES;
    end else if (wr_ctl && vce) begin
      vsel    <= wdata_in[eiv_pkg::VSEL_BIT];         // [R14]
      vce     <= 1'b0;                                // [R16]
      vce_cnt <= '0;
    end else if (vce) begin
      // Select writes outside the window leave everything alone
      vce_cnt <= vce_cnt - 3'h1;
      if (vce_cnt == 3'h1) vce <= 1'b0;               // [R16]
    end
  end

  // Blocking lasts through the instruction after the select write
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      block_hold <= 1'b0;
    end else if (wr_ctl && vce && !wdata_in[eiv_pkg::VCE_BIT]) begin
      block_hold <= 1'b1;                             // [R17]
    end else if (instr_done_in) begin
      block_hold <= 1'b0;
    end
  end

  always_comb begin
    block_seq = vce || block_hold ||
                (wr_ctl && wdata_in[eiv_pkg::VCE_BIT]);  // [R17]
  end

  // ----------------------------------------------------------------
  // Request gating and outputs
  // ----------------------------------------------------------------
  logic       lock_block;
  logic [4:0] next_req;
  logic [4:0] raw_req;

  // Global enable is only read here, never changed
  assign lock_block = (vsel && !exec_boot_in && app_lock_bit_in) ||
                      (!vsel && exec_boot_in && boot_lock_bit_in); // [R18]

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      raw_req[i] = ext_mask[i] &&
                   (is_level(sense_ctl[2*i +: 2]) ? lvl[i]   // [R5]
                                                  : ext_pend[i]);
    end
    raw_req[4:2] = bank_en & bank_pend;                       // [R20]
    next_req = (global_ie_in && !block_seq && !lock_block)
               ? raw_req : 5'h00;                             // [R10]
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_req_out             <= '0;
      vector_table_select_out <= 1'b0;
      wake_out                <= 1'b0;
    end else begin
      irq_req_out             <= next_req;
      vector_table_select_out <= vsel;                        // [R14]
      // Wake ignores global enable and sequence blocking on purpose
      wake_out <= |(ext_mask & lvl &
                    {is_level(sense_ctl[3:2]), is_level(sense_ctl[1:0])})
                  || |(bank_en & bank_hit);                   // [R6] [R8]
    end
  end

  // Read data is registered; unmapped addresses read zero
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      unique case (eff_addr)
        eiv_pkg::ADDR_SENSE:     rdata_out <= sense_ctl;
        eiv_pkg::ADDR_EXT_MASK:  rdata_out <= {6'h00, ext_mask};
        eiv_pkg::ADDR_EXT_FLAGS: rdata_out <= {6'h00, ext_pend};
        eiv_pkg::ADDR_CHG_FLAGS: rdata_out <= {5'h00, bank_pend};
        eiv_pkg::ADDR_CHG_EN:    rdata_out <= {5'h00, bank_en};
        eiv_pkg::ADDR_CHG_MASK0: rdata_out <= 8'(bank_mask[0]);
        eiv_pkg::ADDR_CHG_MASK1: rdata_out <= 8'(bank_mask[1]);
        eiv_pkg::ADDR_CHG_MASK2: rdata_out <= 8'(bank_mask[2]);
        eiv_pkg::ADDR_CORE_CTL:  rdata_out <= {6'h00, vsel, vce};
        default:                 rdata_out <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // One clock for every check; all of them pause while reset is low
  default clocking chk_cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  vce_timeout_a: assert property (  // [R16]
    $rose(vce) ##0 (!wr_ctl) [*4] |=> !vce)
    else $error("change enable not cleared after four cycles");
  level_flag_a: assert property (  // [R12]
    is_level(sense_ctl[1:0]) |=> !ext_pend[0])
    else $error("pin zero flag set in level mode");
  edge_flag_a: assert property (  // [R11]
    hit[1] && !is_level(sense_ctl[3:2]) |=> ext_pend[1])
    else $error("edge did not set pin one flag");
  bank_flag_a: assert property (  // [R22]
    bank_hit[0] |=> bank_pend[0])
    else $error("bank zero change lost");
  seq_block_a: assert property (  // [R17]
    vce |=> irq_req_out == 5'h00)
    else $error("request leaked during change sequence");
  global_gate_a: assert property (  // [R10]
    !global_ie_in |=> irq_req_out == 5'h00)
    else $error("request without global enable");
  level_req_a: assert property (  // [R5]
    global_ie_in && ext_mask[0] && is_level(sense_ctl[1:0]) && lvl[0]
    && !block_seq && !lock_block |=> irq_req_out[0])
    else $error("level request missing");
  vsel_hold_a: assert property (  // [R16]
    !vce && !(wr_ctl && wdata_in[eiv_pkg::VCE_BIT]) |=> $stable(vsel))
    else $error("select changed outside window");
  lock_gate_a: assert property (  // [R18]
    lock_block |=> irq_req_out == 5'h00)
    else $error("request despite boot lock");
  io_alias_a: assert property (  // [R19]
    rd_in && io_space_in && addr_in == 8'h1D |=>
    rdata_out == {6'h00, $past(ext_mask)})
    else $error("I/O alias read wrong");

  vsel_move_c: cover property (@(posedge clk_in) $rose(vsel));
  chg_req_c:   cover property (@(posedge clk_in) irq_req_out[4]);
  edge_req_c:  cover property (@(posedge clk_in) irq_req_out[1]);
endmodule
`default_nettype wire

// File: dv/eiv_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Board-side driver of the dedicated and pin-change inputs
// ----------------------------------------------------------------
module eiv_pin_model (
  input  wire logic        clk_in,
  input  wire logic [1:0]  pin_req_in,
  input  wire logic [23:0] chg_req_in,
  output var  logic [1:0]  ext_pin_out,
  output var  logic [23:0] change_input_out
);
  // Levels move only on falling edges and hold until the next request,
  // so no pulse is ever shorter than a whole clock
  always @(negedge clk_in) begin
    ext_pin_out      <= pin_req_in;
    change_input_out <= chg_req_in;
  end
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  fails++; $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_in, reset_n_in, io, wr, rd, gie, idone, xboot;
  logic        alock, block, vsel, wake, e, v0, v1;
  logic [7:0]  addr, wdata, rdata, rv, msk;
  logic [4:0]  ack, irq;
  logic [1:0]  pin_req, pins, m;
  logic [23:0] chg_req, chg;
  int          fails, num_checks, cycles;

  eiv_pin_model eiv_pin_model_inst (.clk_in(clk_in), .pin_req_in(pin_req),
    .chg_req_in(chg_req), .ext_pin_out(pins), .change_input_out(chg));
  eiv_ctl #(.BANK_W(8)) eiv_ctl_inst (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .addr_in(addr), .io_space_in(io), .wr_in(wr),
    .rd_in(rd), .wdata_in(wdata), .global_ie_in(gie),
    .instr_done_in(idone), .exec_boot_in(xboot), .app_lock_bit_in(alock),
    .boot_lock_bit_in(block), .vector_ack_in(ack), .ext_pin_in(pins),
    .change_input_in(chg), .rdata_out(rdata), .irq_req_out(irq),
    .vector_table_select_out(vsel), .wake_out(wake));

  // ----------------------------------------------------------------
  // Clock, timeout and bus tasks
  // ----------------------------------------------------------------
  initial begin
    clk_in = 0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Ceiling well above the seven hundred or so cycles the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      $display("Error t=%0t timeout", $time);
      wrap_up();
    end
  end
  // One-cycle write strobe; I/O form sends the address less 0x20
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d,
                        input logic i = 1'b0);
    @(negedge clk_in);
    addr = i ? a - 8'h20 : a;
    io = i;
    wdata = d;
    wr = 1;
    @(negedge clk_in);
    wr = 0;
    io = 0;
  endtask
  // Read data is taken a full cycle after the strobe, where it has settled
  task automatic rd_reg(input logic [7:0] a, input logic i = 1'b0);
    @(negedge clk_in);
    addr = i ? a - 8'h20 : a;
    io = i;
    rd = 1;
    @(negedge clk_in);
    rd = 0;
    io = 0;
    @(negedge clk_in);
    rv = rdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  function automatic logic hit(input logic [1:0] md, input logic o,
                               input logic n);
    case (md)
      eiv_pkg::SENSE_LOW:  return !n;
      eiv_pkg::SENSE_ANY:  return o != n;
      eiv_pkg::SENSE_FALL: return o & !n;
      default:             return !o & n;
    endcase
  endfunction
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {io, wr, rd, gie, idone, xboot, alock, block} = 8'h00;
    {addr, wdata, ack, chg_req} = 45'h0;
    pin_req = 2'h3;
    reset_n_in = 0;
    void'($urandom(58974));
    wt(3);
    reset_n_in = 1;
    // Reset values, plus six unmapped places
    for (int k = 0; k < 8; k++) begin
      rd_reg(8'h3B + 8'(k * 7));
      `CHK(rv, 8'h00)
    end
    `CHK(vsel, 1'b0)
    $display("test reset done");
    wr_reg(eiv_pkg::ADDR_EXT_MASK, 8'h03, 1'b1);
    rd_reg(eiv_pkg::ADDR_EXT_MASK, 1'b1);
    `CHK(rv, 8'h03)
    gie = 1;
    // Every sense mode on both pins, fixed transitions then random ones
    for (int p = 0; p < 2; p++) begin
      for (int mi = 0; mi < 4; mi++) begin
        for (int k = 0; k < 3; k++) begin
          m = mi[1:0];
          v0 = (k < 2) ? k[0] : 1'($urandom);
          v1 = (k < 2) ? !v0 : 1'($urandom);
          wr_reg(eiv_pkg::ADDR_SENSE, 8'(m) << (2 * p));
          pin_req[p] <= v0;
          wt(6);
          wr_reg(eiv_pkg::ADDR_EXT_FLAGS, 8'h03);
          pin_req[p] <= v1;
          wt(8);
          e = hit(m, v0, v1);
          `CHK(irq[p], e)
          rd_reg(eiv_pkg::ADDR_EXT_FLAGS);
          `CHK(rv[p], e & (m != eiv_pkg::SENSE_LOW))
          if (m == eiv_pkg::SENSE_LOW) `CHK(wake, !v1)
          pin_req <= 2'h3;
        end
      end
    end
    $display("test sense done");
    // Pending rising edge on pin zero, then gating and relocation
    wr_reg(eiv_pkg::ADDR_SENSE, 8'h03);
    pin_req[0] <= 0;
    wt(6);
    wr_reg(eiv_pkg::ADDR_EXT_FLAGS, 8'h03);
    pin_req[0] <= 1;
    wt(8);
    `CHK(irq[0], 1'b1)
    gie = 0;
    wt(3);
    `CHK(irq[0], 1'b0)
    gie = 1;
    wr_reg(eiv_pkg::ADDR_CORE_CTL, 8'h01);
    wr_reg(eiv_pkg::ADDR_CORE_CTL, 8'h02);
    wt(2);
    `CHK(vsel, 1'b1)
    `CHK(irq[0], 1'b0)
    idone = 1;
    wt(1);
    idone = 0;
    wt(4);
    `CHK(irq[0], 1'b1)
    alock = 1;
    wt(3);
    `CHK(irq[0], 1'b0)
    xboot = 1;
    wt(3);
    `CHK(irq[0], 1'b1)
    {alock, xboot} = 2'h0;
    wr_reg(eiv_pkg::ADDR_CORE_CTL, 8'h00);
    wt(2);
    `CHK(vsel, 1'b1)
    // Change window that lapses with no select write
    wr_reg(eiv_pkg::ADDR_CORE_CTL, 8'h01);
    `CHK(irq[0], 1'b0)
    wt(8);
    `CHK(irq[0], 1'b1)
    rd_reg(eiv_pkg::ADDR_CORE_CTL);
    `CHK(rv, 8'h02)
    wr_reg(eiv_pkg::ADDR_CORE_CTL, 8'h01);
    wr_reg(eiv_pkg::ADDR_CORE_CTL, 8'h00);
    idone = 1;
    wt(1);
    idone = 0;
    wt(2);
    `CHK(vsel, 1'b0)
    {block, xboot} = 2'h3;
    wt(3);
    `CHK(irq[0], 1'b0)
    {block, xboot} = 2'h0;
    ack = 5'h01;
    wt(1);
    ack = 5'h00;
    wt(3);
    rd_reg(eiv_pkg::ADDR_EXT_FLAGS);
    `CHK(rv[0], 1'b0)
    $display("test vector done");
    // Banks: masked-out toggle is ignored, masked-in toggle flags
    wr_reg(eiv_pkg::ADDR_EXT_MASK, 8'h00);
    wr_reg(eiv_pkg::ADDR_CHG_EN, 8'h07);
    for (int b = 0; b < 3; b++) begin
      msk = 8'($urandom | 1) & 8'h7F;
      wr_reg(eiv_pkg::ADDR_CHG_MASK0 + 8'(b), msk | 8'h80);
      rd_reg(eiv_pkg::ADDR_CHG_MASK0 + 8'(b));
      `CHK(rv, (b == 1) ? msk : msk | 8'h80)
      // Bit 7 is masked out in every bank from here on, then toggled
      if (b != 1) wr_reg(eiv_pkg::ADDR_CHG_MASK0 + 8'(b), msk);
      chg_req <= chg_req ^ (24'h80 << (8 * b));
      wt(8);
      rd_reg(eiv_pkg::ADDR_CHG_FLAGS);
      `CHK(rv, 8'h00)
      chg_req <= chg_req ^ (24'h1 << (8 * b));
      wt(8);
      `CHK(irq[2 + b], 1'b1)
      rd_reg(eiv_pkg::ADDR_CHG_FLAGS);
      `CHK(rv, 8'h01 << b)
      wr_reg(eiv_pkg::ADDR_CHG_FLAGS, 8'h01 << b);
      rd_reg(eiv_pkg::ADDR_CHG_FLAGS);
      `CHK(rv, 8'h00)
    end
    // Service entry clears a bank flag just as a one written does
    chg_req <= chg_req ^ 24'h010000;
    wt(4);
    `CHK(irq[4], 1'b1)
    ack = 5'h10;
    wt(1);
    ack = 5'h00;
    rd_reg(eiv_pkg::ADDR_CHG_FLAGS);
    `CHK(rv, 8'h00)
    $display("test banks done");
    wrap_up();
  end
endmodule
`default_nettype wire
